// ===== bench/asbsr_exec_model.sv
// Behavioural model of the instruction execution side.
`timescale 1ns/1ns
module asbsr_exec_model
(
  // Clock
  input  wire logic       i_ref_clk,
  // Instruction outputs
  output logic [3:0]      o_op,
  output logic [7:0]      o_opa,
  output logic [7:0]      o_opb,
  output logic [3:0]      o_ev
);
  initial {o_op, o_opa, o_opb, o_ev} = '0;
  // Event bits are {clear, watchdog clear, sleep, time-out}; the clear is only
  // issued beside a register write, never as a free modify path.
  // Operands turn to their inverse afterwards so a stale value cannot pass.
  task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
                       input logic [3:0] ev);
    @(posedge i_ref_clk);
    o_op <= op;
    o_opa <= a;
    o_opb <= b;
    o_ev <= ev;
    @(posedge i_ref_clk);
    o_op <= 4'h0;
    o_opa <= ~a;
    o_opb <= ~b;
    o_ev <= 4'h0;
  endtask
endmodule

// ===== bench/asbsr_top_monitor.sv
// Port-level checker for the status register block.
`timescale 1ns/1ns
module asbsr_top_monitor
  import asbsr_pkg::*;
(
  // Clock, reset and register port
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Instruction side and outputs
  input wire logic [3:0] i_op,
  input wire logic [7:0] i_opa,
  input wire logic [7:0] i_opb,
  input wire logic       i_clear_register_instr,
  input wire logic       i_watchdog_clear_instr,
  input wire logic       i_sleep_instr,
  input wire logic       i_watchdog_timer_timeout,
  input wire logic [7:0] o_alu_result,
  input wire logic [6:0] i_direct_offset,
  input wire logic [7:0] i_indirect_ptr,
  input wire logic [8:0] o_direct_addr,
  input wire logic [8:0] o_indirect_addr,
  input wire logic [7:0] o_status
);
  // ==========================================================================
  // Reference arithmetic
  // ==========================================================================
  logic       st_sel;
  logic       evt;
  logic       is_sub;
  logic       rot_out;
  logic [8:0] alu_sum;
  logic [4:0] nib_sum;
  assign st_sel = i_addr[6:0] == ASBSR_STATUS_LOW_OFS;
  assign evt = i_watchdog_clear_instr | i_sleep_instr | i_watchdog_timer_timeout;
  assign is_sub = i_op == 4'h2;
  // Subtraction adds the two's complement, so the carries read as inverted borrows.
  assign alu_sum = {1'b0, i_opa} + (is_sub ? {1'b0, ~i_opb} + 9'h001 : {1'b0, i_opb});
  assign nib_sum = {1'b0, i_opa[3:0]} +
                   (is_sub ? {1'b0, ~i_opb[3:0]} + 5'h01 : {1'b0, i_opb[3:0]});
  assign rot_out = (i_op == 4'h4) ? i_opa[0] : i_opa[7];

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_read; i_rd && st_sel |=> o_rdata == $past(o_status); endproperty
  property p_sw_wr;
    i_wr && st_sel && i_op == 4'h0 && !i_clear_register_instr && !evt |=>
      o_status == {$past(i_wdata[7:5]), $past(o_status[4:3]), $past(i_wdata[2:0])};
  endproperty
  property p_clear;
    i_wr && st_sel && i_clear_register_instr && i_op == 4'h0 && !evt |=>
      o_status == {3'h0, $past(o_status[4:3]), 1'b1, $past(o_status[1:0])};
  endproperty
  property p_arith;
    (i_op == 4'h1 || is_sub) && !i_clear_register_instr |=> o_alu_result == $past(alu_sum[7:0])
      && o_status[2:0] == {$past(alu_sum[7:0]) == 8'h00, $past(nib_sum[4]), $past(alu_sum[8])};
  endproperty
  property p_logic;
    i_op == 4'h3 && !i_clear_register_instr |=>
      o_status[2] == (o_alu_result == 8'h00) && $stable(o_status[1:0]);
  endproperty
  property p_rot; i_op == 4'h4 || i_op == 4'h5 |=> o_status[0] == $past(rot_out); endproperty
  property p_tmo; i_watchdog_timer_timeout |=> !o_status[4]; endproperty
  property p_slp; i_sleep_instr && !i_watchdog_timer_timeout |=> o_status[4:3] == 2'b10;
  endproperty
  property p_wdc;
    i_watchdog_clear_instr && !i_sleep_instr && !i_watchdog_timer_timeout |=>
      o_status[4:3] == 2'b11;
  endproperty
  property p_bank;
    o_direct_addr == {o_status[6:5], i_direct_offset} &&
      o_indirect_addr == {o_status[7], i_indirect_ptr};
  endproperty
  a_read: assert property (p_read) else $error("read data not status");
  a_sw_wr: assert property (p_sw_wr) else $error("status write wrong");
  a_clear: assert property (p_clear) else $error("clear result wrong");
  a_arith: assert property (p_arith) else $error("add or sub flags wrong");
  a_logic: assert property (p_logic) else $error("logic flags wrong");
  a_rot: assert property (p_rot) else $error("rotate carry wrong");
  a_tmo: assert property (p_tmo) else $error("time-out kept set");
  a_slp: assert property (p_slp) else $error("sleep flags wrong");
  a_wdc: assert property (p_wdc) else $error("watchdog clear flags wrong");
  a_bank: assert property (p_bank) else $error("bank address wrong");
  c_clear: cover property (i_wr && st_sel && i_clear_register_instr);
  c_sub: cover property (is_sub);
  c_sleep: cover property (i_sleep_instr);
endmodule

bind asbsr_top asbsr_top_monitor i_mon (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_op(i_op), .i_opa(i_opa), .i_opb(i_opb),
  .i_clear_register_instr(i_clear_register_instr), .i_sleep_instr(i_sleep_instr),
  .i_watchdog_clear_instr(i_watchdog_clear_instr), .o_alu_result(o_alu_result),
  .i_watchdog_timer_timeout(i_watchdog_timer_timeout), .i_direct_offset(i_direct_offset),
  .i_indirect_ptr(i_indirect_ptr), .o_direct_addr(o_direct_addr),
  .o_indirect_addr(o_indirect_addr), .o_status(o_status)
);

// ===== bench/asbsr_top_tb.sv
// Self-checking bench for the status register block.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module asbsr_top_tb
  import asbsr_pkg::*;
;
  typedef struct {logic [3:0] op; logic [7:0] a, b, r; logic [2:0] f;} asbsr_row_t;
  logic       i_ref_clk = 1'b0;
  logic       i_rstn = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] op, ev;
  logic [7:0] opa, opb, rdata, res, status;
  logic [8:0] daddr, iaddr;
  logic [1:0] dbs;
  logic       ibs, irq;
  int         failures = 0;
  int         n_checks = 0;
  // Flags are {zero, digit carry, carry}; rotates use the carry left by the row before.
  asbsr_row_t rows [9] = '{'{4'h1, 8'h0F, 8'h01, 8'h10, 3'h2}, '{4'h1, 8'hF0, 8'h10, 8'h00, 3'h5},
    '{4'h2, 8'h05, 8'h05, 8'h00, 3'h7}, '{4'h2, 8'h10, 8'h01, 8'h0F, 3'h1},
    '{4'h2, 8'h01, 8'h02, 8'hFF, 3'h0}, '{4'h3, 8'h00, 8'h00, 8'h00, 3'h4},
    '{4'h3, 8'h5A, 8'h00, 8'h5A, 3'h0}, '{4'h4, 8'h81, 8'h00, 8'h40, 3'h1},
    '{4'h5, 8'h80, 8'h00, 8'h01, 3'h1}};
  logic [3:0] evs [5] = '{4'h2, 4'h4, 4'h1, 4'h3, 4'h4};
  logic [2:0] exp_ev [5] = '{3'h2, 3'h3, 3'h5, 3'h4, 3'h7};

  always #25 i_ref_clk = ~i_ref_clk;

  asbsr_exec_model i_exec (
    .i_ref_clk(i_ref_clk), .o_op(op), .o_opa(opa), .o_opb(opb), .o_ev(ev)
  );
  asbsr_top i_dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_op(op), .i_opa(opa), .i_opb(opb),
    .i_clear_register_instr(ev[3]), .i_watchdog_clear_instr(ev[2]), .i_sleep_instr(ev[1]),
    .i_watchdog_timer_timeout(ev[0]), .o_alu_result(res), .i_direct_offset(7'h12),
    .i_indirect_ptr(8'h34), .o_direct_addr(daddr), .o_indirect_addr(iaddr),
    .o_direct_bank_select(dbs), .o_indirect_bank_select(ibs), .o_status(status), .o_irq(irq)
  );

  // ==========================================================================
  // Bus tasks and closing
  // ==========================================================================
  task automatic bus_wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_ref_clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_ref_clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    repeat (3) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    foreach (rows[k])
    begin
      i_exec.issue(rows[k].op, rows[k].a, rows[k].b, 4'h0);
      #1;
      `CHK("result", rows[k].r, res)
      `CHK("flags", rows[k].f, status[2:0])
    end
    $display("test rows done");
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    `CHK("reset status", 8'h18, status)
    `CHK("reset irq", 1'b0, irq)
    i_rstn <= 1'b1;
    $display("test reset done");
    bus_wr(9'h103, 8'hA5);
    #1;
    `CHK("status", 8'hBD, status)
    `CHK("dbank", 2'h1, dbs)
    `CHK("ibank", 1'b1, ibs)
    `CHK("daddr", 9'h092, daddr)
    `CHK("iaddr", 9'h134, iaddr)
    for (int k = 0; k < 4; k++)
      bus_rd({k[1:0], 7'h03}, 8'hBD);
    bus_rd(9'h1FF, 8'h00);
    fork
      i_exec.issue(4'h0, 8'h00, 8'h00, 4'h8);
      bus_wr(ASBSR_STATUS_OFS, 8'hFF);
    join
    #1;
    `CHK("clear", 8'h1D, status)
    fork
      i_exec.issue(4'h1, 8'h0F, 8'h01, 4'h0);
      bus_wr(9'h083, 8'h00);
    join
    #1;
    `CHK("flag write", 8'h1A, status)
    $display("test writes done");
    bus_wr(ASBSR_IRQ_CLR_OFS, 8'h0F);
    bus_wr(ASBSR_IRQ_EN_OFS, 8'h01);
    bus_rd(ASBSR_IRQ_EN_OFS, 8'h01);
    foreach (evs[k])
    begin
      i_exec.issue(4'h0, 8'h00, 8'h00, evs[k]);
      #1;
      `CHK("event", exp_ev[k], {irq, status[4:3]})
    end
    bus_rd(ASBSR_IRQ_STAT_OFS, 8'h07);
    bus_wr(ASBSR_IRQ_CLR_OFS, 8'h01);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    bus_rd(ASBSR_IRQ_STAT_OFS, 8'h06);
    bus_rd(ASBSR_IRQ_CLR_OFS, 8'h00);
    $display("test events done");
    report_and_stop();
  end

  // A hang past about thirty times the expected run length ends the run as failed.
  initial
  begin
    repeat (2000) @(posedge i_ref_clk);
    failures++;
    report_and_stop();
  end
endmodule

// ===== src/asbsr_flag_alu.sv
// Flag computation for add, subtract, logic and rotate-through-carry operations.
`timescale 1ns/1ns
module asbsr_flag_alu
  import asbsr_pkg::*;
(
  // Operation and operands
  input  wire logic [3:0] i_op,
  input  wire logic [7:0] i_opa,
  input  wire logic [7:0] i_opb,
  input  wire logic       i_carry_in,
  // Results
  output logic [7:0]      o_result,
  output logic            o_zero,
  output logic            o_dc,
  output logic            o_carry,
  output logic            o_sets_zero,
  output logic            o_sets_dc_c,
  output logic            o_sets_c_only
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] opb_eff;
  logic       cin;

  // Subtraction adds the two's complement so carry reads as inverted borrow.
  always_comb
  begin
    opb_eff = (i_op == ASBSR_OP_SUB) ? ~i_opb : i_opb;
    cin     = (i_op == ASBSR_OP_SUB);
    sum     = {1'b0, i_opa} + {1'b0, opb_eff} + {8'h00, cin};
    nib     = {1'b0, i_opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
  end

  always_comb
  begin
    o_result      = 8'h00;
    o_dc          = 1'b0;
    o_carry       = 1'b0;
    o_sets_zero   = 1'b0;
    o_sets_dc_c   = 1'b0;
    o_sets_c_only = 1'b0;
    unique case (i_op)
      ASBSR_OP_ADD, ASBSR_OP_SUB:
      begin
        o_result    = sum[7:0];
        o_dc        = nib[ASBSR_NIBBLE_BITS];
        o_carry     = sum[8];
        o_sets_zero = 1'b1;
        o_sets_dc_c = 1'b1;
      end
      ASBSR_OP_LOGIC:
      begin
        o_result    = i_opa;
        o_sets_zero = 1'b1;
      end
      ASBSR_OP_RRC:
      begin
        o_result      = {i_carry_in, i_opa[7:1]};
        o_carry       = i_opa[0];
        o_sets_c_only = 1'b1;
      end
      ASBSR_OP_RLC:
      begin
        o_result      = {i_opa[6:0], i_carry_in};
        o_carry       = i_opa[7];
        o_sets_c_only = 1'b1;
      end
      default:
      begin
        o_result = i_opa;
      end
    endcase
    o_zero = (o_result == 8'h00);
  end

endmodule

// ===== src/asbsr_pkg.sv
// Package of constants and types for the ALU status and bank select register block.
package asbsr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [8:0] ASBSR_STATUS_OFS     = 9'h003;
  localparam logic [6:0] ASBSR_STATUS_LOW_OFS = 7'h03;
  localparam logic [8:0] ASBSR_IRQ_STAT_OFS   = 9'h00C;
  localparam logic [8:0] ASBSR_IRQ_CLR_OFS    = 9'h00D;
  localparam logic [8:0] ASBSR_IRQ_EN_OFS     = 9'h00E;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int ASBSR_CARRY_BIT   = 0;
  localparam int ASBSR_DC_BIT      = 1;
  localparam int ASBSR_ZERO_BIT    = 2;
  localparam int ASBSR_PD_BIT      = 3;
  localparam int ASBSR_TO_BIT      = 4;
  localparam int ASBSR_RP_LO_BIT   = 5;
  localparam int ASBSR_RP_HI_BIT   = 6;
  localparam int ASBSR_IRP_BIT     = 7;
  localparam int ASBSR_BANK_BYTES  = 128;
  localparam int ASBSR_NIBBLE_BITS = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [2:0] ASBSR_BANK_RST  = 3'h0;
  localparam logic       ASBSR_TO_RST    = 1'b1;
  localparam logic       ASBSR_PD_RST    = 1'b1;
  localparam logic [2:0] ASBSR_ARITH_RST = 3'h0;
  localparam logic [3:0] ASBSR_IRQ_RST   = 4'h0;

  // ==========================================================================
  // Operations
  // ==========================================================================
  typedef enum logic [3:0]
  {
    ASBSR_OP_NONE  = 4'h0,
    ASBSR_OP_ADD   = 4'h1,
    ASBSR_OP_SUB   = 4'h2,
    ASBSR_OP_LOGIC = 4'h3,
    ASBSR_OP_RRC   = 4'h4,
    ASBSR_OP_RLC   = 4'h5
  } asbsr_op_t;

  // Interrupt status bit positions.
  localparam int ASBSR_IRQ_TIMEOUT = 0;
  localparam int ASBSR_IRQ_SLEEP   = 1;
  localparam int ASBSR_IRQ_CLRWD   = 2;
  localparam int ASBSR_IRQ_ZERO    = 3;

endpackage

// ===== src/asbsr_top.sv
// Status register with flags, reset-status bits, bank selects and event interrupt.
`timescale 1ns/1ns

// Overview of operation
// - Any instruction may write the status register as an ordinary data register.
// - A flag-affecting instruction writing here has the write to zero, digit carry and carry blocked; only the flags it affects change.
// - Software writes never change the time-out and power-down flags.
// - Clearing the register zeros the bank bits, sets zero, and keeps the other bits.
// - The register answers at the same low offset in each of the four banks.
// - Bits 6:5 select one of four 128-byte banks for direct addressing.
// - Time-out is set on power-up, watchdog clear and sleep, cleared by a watchdog time-out.
// - Power-down is set on power-up and watchdog clear, cleared by sleep.
// - Zero is set when an add, subtract or logic result is zero and cleared otherwise.
// - Digit carry holds the carry out of the fourth low bit for add and subtract.
// - Carry holds the top carry; for subtract both carries are inverted borrows.
module asbsr_top
  import asbsr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // Register port
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  // Instruction execution
  input  wire logic [3:0] i_op,
  input  wire logic [7:0] i_opa,
  input  wire logic [7:0] i_opb,
  input  wire logic       i_clear_register_instr,
  input  wire logic       i_watchdog_clear_instr,
  input  wire logic       i_sleep_instr,
  input  wire logic       i_watchdog_timer_timeout,
  output logic [7:0]      o_alu_result,
  // Addressing outputs
  input  wire logic [6:0] i_direct_offset,
  input  wire logic [7:0] i_indirect_ptr,
  output logic [8:0]      o_direct_addr,
  output logic [8:0]      o_indirect_addr,
  output logic [1:0]      o_direct_bank_select,
  output logic            o_indirect_bank_select,
  // Flags and interrupt
  output logic [7:0]      o_status,
  output logic            o_irq
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [1:0] direct_bank_select_q;
  logic       indirect_bank_select_q;
  logic       watchdog_timeout_flag_q;
  logic       power_down_flag_q;
  logic       zero_flag_q;
  logic       digit_carry_flag_q;
  logic       carry_flag_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic [7:0] rdata_q;
  logic [7:0] alu_result_q;

  logic [7:0] status_now;
  logic [7:0] alu_res;
  logic       alu_zero;
  logic       alu_dc;
  logic       alu_c;
  logic       sets_zero;
  logic       sets_dc_c;
  logic       sets_c_only;
  logic       status_hit;
  logic       sw_wr;
  logic       prot_arith;
  logic [7:0] wr_value;
  logic [3:0] irq_evt;

  asbsr_flag_alu u_flag_alu
  (
    .i_op          (i_op),
    .i_opa         (i_opa),
    .i_opb         (i_opb),
    .i_carry_in    (carry_flag_q),
    .o_result      (alu_res),
    .o_zero        (alu_zero),
    .o_dc          (alu_dc),
    .o_carry       (alu_c),
    .o_sets_zero   (sets_zero),
    .o_sets_dc_c   (sets_dc_c),
    .o_sets_c_only (sets_c_only)
  );

  // ==========================================================================
  // Decode
  // ==========================================================================
  assign status_now = {indirect_bank_select_q, direct_bank_select_q, watchdog_timeout_flag_q,
                       power_down_flag_q, zero_flag_q, digit_carry_flag_q, carry_flag_q};

  // Only the low seven bits are compared so every bank reaches the same register.
  assign status_hit = (i_addr[6:0] == ASBSR_STATUS_LOW_OFS);
  assign sw_wr      = i_wr && status_hit;
  // A clear instruction behaves as a flag-affecting write of zero.
  assign prot_arith = sets_zero || sets_c_only || i_clear_register_instr;
  assign wr_value   = i_clear_register_instr ? 8'h00 : i_wdata;

  // ==========================================================================
  // Bank select bits
  // ==========================================================================
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      direct_bank_select_q   <= ASBSR_BANK_RST[1:0];
      indirect_bank_select_q <= ASBSR_BANK_RST[2];
    end
    else if (sw_wr)
    begin
      direct_bank_select_q   <= wr_value[ASBSR_RP_HI_BIT:ASBSR_RP_LO_BIT];
      indirect_bank_select_q <= wr_value[ASBSR_IRP_BIT];
    end
  end

  // ==========================================================================
  // Reset-status flags, hardware only
  // ==========================================================================
  // Software writes are not looked at here at all, so they can never alter these bits.
  // A time-out in the same cycle as a watchdog clear or sleep leaves the flag cleared.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      watchdog_timeout_flag_q <= ASBSR_TO_RST;
    end
    else if (i_watchdog_timer_timeout)
    begin
      watchdog_timeout_flag_q <= 1'b0;
    end
    else if (i_watchdog_clear_instr || i_sleep_instr)
    begin
      watchdog_timeout_flag_q <= 1'b1;
    end
  end

  // Sleep wins over a watchdog clear in the same cycle, so the part reads as powered down.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      power_down_flag_q <= ASBSR_PD_RST;
    end
    else if (i_sleep_instr)
    begin
      power_down_flag_q <= 1'b0;
    end
    else if (i_watchdog_clear_instr)
    begin
      power_down_flag_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Arithmetic flags
  // ==========================================================================
  // The arithmetic flags are undefined after power-up; zero is used so simulation stays clean.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      zero_flag_q <= ASBSR_ARITH_RST[ASBSR_ZERO_BIT];
    end
    else if (i_clear_register_instr && sw_wr)
    begin
      zero_flag_q <= 1'b1;
    end
    else if (sets_zero)
    begin
      zero_flag_q <= alu_zero;
    end
    else if (sw_wr && !prot_arith)
    begin
      zero_flag_q <= wr_value[ASBSR_ZERO_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      digit_carry_flag_q <= ASBSR_ARITH_RST[ASBSR_DC_BIT];
    end
    else if (sets_dc_c)
    begin
      digit_carry_flag_q <= alu_dc;
    end
    else if (sw_wr && !prot_arith)
    begin
      digit_carry_flag_q <= wr_value[ASBSR_DC_BIT];
    end
  end

  // Rotates feed the old carry into the shifted value before this flag takes the new one.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      carry_flag_q <= ASBSR_ARITH_RST[ASBSR_CARRY_BIT];
    end
    else if (sets_dc_c || sets_c_only)
    begin
      carry_flag_q <= alu_c;
    end
    else if (sw_wr && !prot_arith)
    begin
      carry_flag_q <= wr_value[ASBSR_CARRY_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      alu_result_q <= 8'h00;
    end
    else
    begin
      alu_result_q <= alu_res;
    end
  end

  // ==========================================================================
  // Event interrupt
  // ==========================================================================
  assign irq_evt = {sets_zero && alu_zero, i_watchdog_clear_instr, i_sleep_instr,
                    i_watchdog_timer_timeout};

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      irq_stat_q <= ASBSR_IRQ_RST;
    end
    else if (i_wr && i_addr == ASBSR_IRQ_CLR_OFS)
    begin
      irq_stat_q <= (irq_stat_q & ~i_wdata[3:0]) | irq_evt;
    end
    else
    begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      irq_en_q <= ASBSR_IRQ_RST;
    end
    else if (i_wr && i_addr == ASBSR_IRQ_EN_OFS)
    begin
      irq_en_q <= i_wdata[3:0];
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_q <= 8'h00;
    else if (i_rd)
    begin
      if (status_hit)
        rdata_q <= status_now;
      else if (i_addr == ASBSR_IRQ_STAT_OFS)
        rdata_q <= {4'h0, irq_stat_q};
      else if (i_addr == ASBSR_IRQ_EN_OFS)
        rdata_q <= {4'h0, irq_en_q};
      else
        rdata_q <= 8'h00;
    end
    else
      rdata_q <= 8'h00;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_rdata                = rdata_q;
  assign o_status               = status_now;
  assign o_alu_result           = alu_result_q;
  assign o_direct_bank_select   = direct_bank_select_q;
  assign o_indirect_bank_select = indirect_bank_select_q;
  assign o_direct_addr          = {direct_bank_select_q, i_direct_offset};
  assign o_indirect_addr        = {indirect_bank_select_q, i_indirect_ptr};
  assign o_irq                  = |(irq_stat_q & irq_en_q);

endmodule
